// [common/stap_pkg.sv]
// constants and types for the ram test access port
// Behaviour
// - capture-IR loads 01 into low bits
// - shift-IR places instruction register on chain
// - new instruction acts only at update-IR
// - codes: 001 id, 010 float, 011 bypass, 100 sample
// - id instruction captures rom, shifts id register
// - trst and test-logic-reset select id instruction
// - bypass instruction shifts single bypass bit
// - sample captures pads when leaving capture-DR
// - sample shifts boundary register, ram unaffected
// - update-DR under sample acts like pause-DR
// - port only observes pads, never drives
// - all-zeros instruction drives no pins
// - float instruction tristates data, shifts bypass
// - float instruction also captures pad ring
// - bench, not controller, holds pads stable around capture
// - ram clock never paused by the port
// - controller loads any code given, reserved private codes included
// - sample tdi rising, update tdo falling
// - three-bit instruction, one-bit bypass register
// - 32-bit id, bit 0 first, reads one
package stap_pkg;
    localparam int IR_W   = 3;
    localparam int ID_W   = 32;
    localparam int BSR_W  = 70;
    localparam int HOST_DIV = 4;
    localparam logic [1:0]  IR_CAPT   = 2'h1;
    localparam logic [2:0]  INS_ID    = 3'h1;
    localparam logic [2:0]  INS_FLOAT = 3'h2;
    localparam logic [2:0]  INS_BYP   = 3'h3;
    localparam logic [2:0]  INS_SAMP  = 3'h4;
    // arbitrary neutral identity, bit 0 forced to one
    localparam logic [31:0] ID_CODE   = 32'h1000_0001;

    typedef enum logic [15:0] {
        ST_RESET = 16'h0001, ST_IDLE  = 16'h0002, ST_SELDR = 16'h0004,
        ST_CAPDR = 16'h0008, ST_SHDR  = 16'h0010, ST_EX1DR = 16'h0020,
        ST_PSDR  = 16'h0040, ST_EX2DR = 16'h0080, ST_UPDR  = 16'h0100,
        ST_SELIR = 16'h0200, ST_CAPIR = 16'h0400, ST_SHIR  = 16'h0800,
        ST_EX1IR = 16'h1000, ST_PSIR  = 16'h2000, ST_EX2IR = 16'h4000,
        ST_UPIR  = 16'h8000
    } stap_state_e;

    function automatic stap_state_e next_state(stap_state_e s, logic tms);
        case (s)
            ST_RESET: next_state = tms ? ST_RESET : ST_IDLE;
            ST_IDLE:  next_state = tms ? ST_SELDR : ST_IDLE;
            ST_SELDR: next_state = tms ? ST_SELIR : ST_CAPDR;
            ST_CAPDR: next_state = tms ? ST_EX1DR : ST_SHDR;
            ST_SHDR:  next_state = tms ? ST_EX1DR : ST_SHDR;
            ST_EX1DR: next_state = tms ? ST_UPDR  : ST_PSDR;
            ST_PSDR:  next_state = tms ? ST_EX2DR : ST_PSDR;
            ST_EX2DR: next_state = tms ? ST_UPDR  : ST_SHDR;
            ST_UPDR:  next_state = tms ? ST_SELDR : ST_IDLE;
            ST_SELIR: next_state = tms ? ST_RESET : ST_CAPIR;
            ST_CAPIR: next_state = tms ? ST_EX1IR : ST_SHIR;
            ST_SHIR:  next_state = tms ? ST_EX1IR : ST_SHIR;
            ST_EX1IR: next_state = tms ? ST_UPIR  : ST_PSIR;
            ST_PSIR:  next_state = tms ? ST_EX2IR : ST_PSIR;
            ST_EX2IR: next_state = tms ? ST_UPIR  : ST_SHIR;
            ST_UPIR:  next_state = tms ? ST_SELDR : ST_IDLE;
            default:  next_state = ST_RESET;
        endcase
    endfunction
endpackage

// [common/stap_if.sv]
// test port link between board controller and ram
`timescale 1ns/1ps
interface stap_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic trst_n;
    modport dev  (input tck, input tms, input tdi, input trst_n, output tdo);
    modport host (output tck, output tms, output tdi, output trst_n, input tdo);
endinterface

// [rtl/stap_fsm.sv]
// sixteen-state controller stepped by tms
`timescale 1ns/1ps
module stap_fsm
(
    input  wire logic                 tck,
    input  wire logic                 trst_n,
    input  wire logic                 tms,
    output stap_pkg::stap_state_e     state
);
    stap_pkg::stap_state_e state_r;

    // ===================================
    // state register
    // rising edge step
    always_ff @(posedge tck or negedge trst_n)
    begin
        if (!trst_n)
            state_r <= stap_pkg::ST_RESET;
        else
            state_r <= stap_pkg::next_state(state_r, tms);
    end

    assign state = state_r;
endmodule // stap_fsm

// [rtl/stap_dev.sv]
// ram end: instruction logic and data registers on tck
`timescale 1ns/1ps
module stap_dev
(
    stap_if.dev                          link,
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire logic [stap_pkg::BSR_W-1:0] pad_in,
    output logic                         dq_float,
    output logic [2:0]                   active_ins
);
    stap_pkg::stap_state_e          st;
    logic [stap_pkg::IR_W-1:0]      ir_sh_r;
    logic [stap_pkg::IR_W-1:0]      ir_act_r;
    logic [stap_pkg::ID_W-1:0]      id_r;
    logic [stap_pkg::BSR_W-1:0]     bsr_r;
    logic [stap_pkg::BSR_W-1:0]     pad_s1_r;
    logic [stap_pkg::BSR_W-1:0]     pad_s2_r;
    logic                           byp_r;
    logic                           tdo_r;
    logic                           fl_s1_r;
    logic                           fl_s2_r;
    logic [2:0]                     ins_s1_r;
    logic [2:0]                     ins_s2_r;
    logic [2:0]                     ins_s3_r;
    logic [2:0]                     ins_q_r;
    wire                            sel_id;
    wire                            sel_samp;
    wire                            sel_float;
    wire                            do_capdr;
    wire                            do_shdr;
    wire                            sh_bit;

    stap_fsm stap_fsm_inst
    (
        .tck    (link.tck),
        .trst_n (link.trst_n),
        .tms    (link.tms),
        .state  (st)
    );

    // ===================================
    // instruction decode
    // code compare
    assign sel_id    = (ir_act_r == stap_pkg::INS_ID);
    assign sel_samp  = (ir_act_r == stap_pkg::INS_SAMP);
    assign sel_float = (ir_act_r == stap_pkg::INS_FLOAT);
    assign do_capdr  = (st == stap_pkg::ST_CAPDR);
    assign do_shdr   = (st == stap_pkg::ST_SHDR);

    // ===================================
    // instruction register
    always_ff @(posedge link.tck or negedge link.trst_n)
    begin
        if (!link.trst_n)
        begin
            ir_sh_r  <= stap_pkg::INS_ID;
            ir_act_r <= stap_pkg::INS_ID;
        end
        else
        begin
            if (st == stap_pkg::ST_CAPIR)
                ir_sh_r <= {1'b0, stap_pkg::IR_CAPT};
            else if (st == stap_pkg::ST_SHIR)
                ir_sh_r <= {link.tdi, ir_sh_r[stap_pkg::IR_W-1:1]};
            if (st == stap_pkg::ST_RESET)
                ir_act_r <= stap_pkg::INS_ID;
            else if (st == stap_pkg::ST_UPIR)
                ir_act_r <= ir_sh_r;
        end
    end

    // ===================================
    // pad sampling
    // pads are async to tck; capture lags them by two tck
    always_ff @(posedge link.tck)
    begin
        pad_s1_r <= pad_in;
        pad_s2_r <= pad_s1_r;
    end

    // ===================================
    // data registers
    // sample tdi rising
    always_ff @(posedge link.tck)
    begin
        if (do_capdr && sel_id)
            id_r <= stap_pkg::ID_CODE;
        else if (do_shdr && sel_id)
            id_r <= {link.tdi, id_r[stap_pkg::ID_W-1:1]};
        if (do_capdr && (sel_samp || sel_float))
            bsr_r <= pad_s2_r;
        else if (do_shdr && sel_samp)
            bsr_r <= {link.tdi, bsr_r[stap_pkg::BSR_W-1:1]};
        if (do_capdr)
            byp_r <= 1'b0;
        else if (do_shdr)
            byp_r <= link.tdi;
    end

    // ===================================
    // tdo path
    // float and reserved use bypass
    assign sh_bit = (st == stap_pkg::ST_SHIR) ? ir_sh_r[0] :
                    sel_id   ? id_r[0] :
                    sel_samp ? bsr_r[0] : byp_r;

    always_ff @(negedge link.tck)
    begin
        tdo_r <= sh_bit;
    end
    assign link.tdo = tdo_r;

    // ===================================
    // ram-side crossing, levels only
    // only float may act on pins
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            fl_s1_r  <= 1'b0;
            fl_s2_r  <= 1'b0;
            ins_s1_r <= stap_pkg::INS_ID;
            ins_s2_r <= stap_pkg::INS_ID;
            ins_s3_r <= stap_pkg::INS_ID;
            ins_q_r  <= stap_pkg::INS_ID;
        end
        else
        begin
            fl_s1_r  <= sel_float;
            fl_s2_r  <= fl_s1_r;
            ins_s1_r <= ir_act_r;
            ins_s2_r <= ins_s1_r;
            ins_s3_r <= ins_s2_r;
            // a mixed-bit sample lasts one cycle; two equal ones hide it
            if (ins_s2_r == ins_s3_r)
                ins_q_r <= ins_s3_r;
        end
    end

    assign dq_float   = fl_s2_r;
    assign active_ins = ins_q_r;
endmodule // stap_dev

// [rtl/stap_host.sv]
// controller end: drives tck by divider, shifts ir or dr
`timescale 1ns/1ps
module stap_host
(
    stap_if.host                link,
    input  wire logic           sys_clk,
    input  wire logic           rst_n,
    input  wire logic           req_valid,
    input  wire logic           req_is_ir,
    input  wire logic [6:0]     req_len,
    input  wire logic [69:0]    req_data,
    output logic                req_ready,
    output logic                rsp_valid,
    output logic [69:0]         rsp_data
);
    typedef enum logic [3:0]
    {
        H_IDLE = 4'h1, H_NAV = 4'h2, H_SHIFT = 4'h4, H_DONE = 4'h8
    } stap_hst_e;

    stap_hst_e               st_r;
    logic [1:0]              div_r;
    logic                    tck_r;
    logic                    tms_r;
    logic                    tdi_r;
    logic [3:0]              nav_r;
    logic [7:0]              pat_r;
    logic [6:0]              cnt_r;
    logic [69:0]             sh_r;
    logic [69:0]             rsp_r;
    logic                    rv_r;
    logic                    is_ir_r;
    logic                    tdo_s1_r;
    logic                    tdo_s2_r;
    wire                     fall;
    wire                     rise;

    assign fall = (div_r == 2'h1) && tck_r;
    assign rise = (div_r == 2'h1) && !tck_r;

    // ===================================
    // clock divider and sequencer
    // ir codes come from the user; reserved codes are caller's duty
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            st_r     <= H_IDLE;
            div_r    <= 2'h0;
            tck_r    <= 1'b0;
            tms_r    <= 1'b1;
            tdi_r    <= 1'b0;
            nav_r    <= 4'h0;
            pat_r    <= 8'h00;
            cnt_r    <= 7'h00;
            sh_r     <= '0;
            rsp_r    <= '0;
            rv_r     <= 1'b0;
            is_ir_r  <= 1'b0;
            tdo_s1_r <= 1'b0;
            tdo_s2_r <= 1'b0;
        end
        else
        begin
            tdo_s1_r <= link.tdo;
            tdo_s2_r <= tdo_s1_r;
            rv_r     <= 1'b0;
            div_r    <= 2'(div_r + 2'h1);
            if (div_r == 2'h1)
                tck_r <= !tck_r;
            case (st_r)
                H_IDLE:
                    if (req_valid)
                    begin
                        st_r    <= H_NAV;
                        is_ir_r <= req_is_ir;
                        sh_r    <= req_data;
                        cnt_r   <= req_len;
                        pat_r   <= req_is_ir ? 8'h06 : 8'h02;
                        // one extra fall: the capture edge shifts nothing
                        nav_r   <= req_is_ir ? 4'h6 : 4'h5;
                    end
                H_NAV:
                    if (fall)
                    begin
                        tms_r <= pat_r[0];
                        pat_r <= {1'b0, pat_r[7:1]};
                        nav_r <= 4'(nav_r - 4'h1);
                        if (nav_r == 4'h1)
                        begin
                            st_r  <= H_SHIFT;
                            tdi_r <= sh_r[0];
                            tms_r <= (cnt_r == 7'h01);
                        end
                    end
                H_SHIFT:
                    if (rise)
                    begin
                        rsp_r <= {tdo_s2_r, rsp_r[69:1]};
                        sh_r  <= {1'b0, sh_r[69:1]};
                        cnt_r <= 7'(cnt_r - 7'h01);
                        if (cnt_r == 7'h01)
                        begin
                            st_r  <= H_DONE;
                            pat_r <= 8'h01;
                            nav_r <= 4'h2;
                        end
                    end
                    else if (fall)
                    begin
                        tdi_r <= sh_r[0];
                        tms_r <= (cnt_r == 7'h01);
                    end
                H_DONE:
                    // exit1 -> update -> idle
                    if (fall)
                    begin
                        tms_r <= pat_r[0];
                        pat_r <= {1'b0, pat_r[7:1]};
                        nav_r <= 4'(nav_r - 4'h1);
                        if (nav_r == 4'h0)
                        begin
                            st_r <= H_IDLE;
                            rv_r <= 1'b1;
                        end
                    end
                default: st_r <= H_IDLE;
            endcase
        end
    end

    assign link.tck    = tck_r;
    assign link.tms    = tms_r;
    assign link.tdi    = tdi_r;
    assign link.trst_n = rst_n;
    assign req_ready   = (st_r == H_IDLE);
    assign rsp_valid   = rv_r;
    assign rsp_data    = rsp_r;
endmodule // stap_host

// [sim/stap_asserts.sv]
// wire checks beside the test port link
`timescale 1ns/1ps
module stap_asserts
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic trst_n
);
    // ====
    // shadow controller, tracks what the wire implies
    stap_pkg::stap_state_e st_r;
    logic [2:0]            ir_r;
    logic [2:0]            act_r;
    logic [6:0]            cnt_r;
    wire  logic            sh_dr = (st_r == stap_pkg::ST_SHDR);
    wire  logic            sh_ir = (st_r == stap_pkg::ST_SHIR);
    wire  logic            cap   = (st_r == stap_pkg::ST_CAPDR) || (st_r == stap_pkg::ST_CAPIR);
    wire  logic            byp   = (act_r != stap_pkg::INS_ID) && (act_r != stap_pkg::INS_SAMP);
    wire  logic [2:0]      act_nxt = (st_r == stap_pkg::ST_UPIR) ? ir_r :
                                     (st_r == stap_pkg::ST_RESET) ? stap_pkg::INS_ID : act_r;
    always_ff @(posedge tck or negedge trst_n)
    begin
        if (!trst_n)
        begin
            st_r  <= stap_pkg::ST_RESET;
            act_r <= stap_pkg::INS_ID;
            ir_r  <= 3'h0;
            cnt_r <= 7'h00;
        end
        else
        begin
            st_r  <= stap_pkg::next_state(st_r, tms);
            ir_r  <= sh_ir ? {tdi, ir_r[2:1]} : ir_r;
            act_r <= act_nxt;
            cnt_r <= cap ? 7'h00 : cnt_r + {6'h00, sh_dr | sh_ir};
        end
    end
    // ====
    // link timing
    chk_tdo_falling: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(tdo) |-> $fell(tck)) else $error("tdo moved off falling tck");
    chk_tdi_setup: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(tdi) |-> !tck) else $error("tdi moved while tck high");
    chk_tms_setup: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(tms) |-> !tck) else $error("tms moved while tck high");
    chk_reset_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> tms && !tck) else $error("link not idle out of reset");
    // ====
    // shifted contents
    chk_ir_cap_one: assert property (@(posedge tck) disable iff (!trst_n)
        sh_ir && cnt_r == 7'h00 |-> tdo) else $error("ir capture bit 0 not one");
    chk_ir_cap_zero: assert property (@(posedge tck) disable iff (!trst_n)
        sh_ir && cnt_r == 7'h01 |-> !tdo) else $error("ir capture bit 1 not zero");
    chk_id_bits: assert property (@(posedge tck) disable iff (!trst_n)
        sh_dr && act_r == stap_pkg::INS_ID && cnt_r < 7'h20
        |-> tdo == stap_pkg::ID_CODE[cnt_r[4:0]]) else $error("id bit wrong");
    chk_bypass_delay: assert property (@(posedge tck) disable iff (!trst_n)
        sh_dr && byp && cnt_r != 7'h00 && $past(sh_dr) |-> tdo == $past(tdi))
        else $error("bypass not one stage");
    c_id: cover property (@(posedge tck) sh_dr && act_r == stap_pkg::INS_ID);
    c_byp: cover property (@(posedge tck) sh_dr && byp && cnt_r == 7'h07);
    c_samp: cover property (@(posedge tck) sh_dr && act_r == stap_pkg::INS_SAMP);
endmodule // stap_asserts

// [sim/sram_tap_instruction_logic_tb.sv]
// bench joining controller end to ram end
`timescale 1ns/1ps
module sram_tap_instruction_logic_tb;
    logic        sys_clk;
    logic        rst_n;
    logic        req_valid;
    logic        req_is_ir;
    logic [6:0]  req_len;
    logic [69:0] req_data;
    logic [69:0] pad_in;
    logic [69:0] got;
    wire  logic  req_ready;
    wire  logic  rsp_valid;
    wire  [69:0] rsp_data;
    wire  logic  dq_float;
    wire  [2:0]  active_ins;
    int          errors;
    int          check_count;
    stap_if link_if ();
    stap_host stap_host_inst (.link(link_if), .sys_clk(sys_clk), .rst_n(rst_n),
        .req_valid(req_valid), .req_is_ir(req_is_ir), .req_len(req_len), .req_data(req_data),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    stap_dev stap_dev_inst (.link(link_if), .sys_clk(sys_clk), .rst_n(rst_n), .pad_in(pad_in),
        .dq_float(dq_float), .active_ins(active_ins));
    stap_asserts stap_asserts_inst (.sys_clk(sys_clk), .rst_n(rst_n), .tck(link_if.tck),
        .tms(link_if.tms), .tdi(link_if.tdi), .tdo(link_if.tdo), .trst_n(link_if.trst_n));
    // ====
    // shared tasks
    task automatic complete_run();
        if (errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [69:0] g, input logic [69:0] e);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic hang();
        errors++;
        complete_run();
    endtask
    task automatic xfer(input logic ir, input logic [6:0] len, input logic [69:0] d);
        int n;
        for (n = 0; n < 100 && req_ready !== 1'b1; n++) @(negedge sys_clk);
        if (n == 100) hang();
        req_valid = 1'b1;
        req_is_ir = ir;
        req_len   = len;
        req_data  = d;
        @(negedge sys_clk);
        req_valid = 1'b0;
        for (n = 0; n < 2000 && rsp_valid !== 1'b1; n++) @(negedge sys_clk);
        if (n == 2000) hang();
        got = rsp_data >> (70 - len);
    endtask
    task automatic settle(input logic [2:0] ins, input logic flt);
        int n;
        for (n = 0; n < 16 && {active_ins, dq_float} !== {ins, flt}; n++) @(negedge sys_clk);
        chk({67'h0, active_ins}, {67'h0, ins});
        chk({69'h0, dq_float}, {69'h0, flt});
    endtask
    task automatic load_ir(input logic [2:0] c);
        xfer(1'b1, 7'h03, {67'h0, c});
        chk(got & 70'h3, 70'h1);
    endtask
    // ====
    // scenarios
    task automatic t_id();
        settle(stap_pkg::INS_ID, 1'b0);
        xfer(1'b0, 7'h20, 70'h0);
        chk(got, {38'h0, stap_pkg::ID_CODE});
    endtask
    task automatic t_byp(input logic [2:0] c, input logic flt);
        load_ir(c);
        settle(c, flt);
        xfer(1'b0, 7'h08, 70'hA5);
        chk(got, 70'h4A);
    endtask
    task automatic t_samp();
        pad_in = 70'h2A_5A5A_C3C3_0F0F_1234;
        load_ir(stap_pkg::INS_SAMP);
        // pads held still across each capture
        xfer(1'b0, 7'h46, 70'h0);
        chk(got, pad_in);
        pad_in = ~pad_in;
        xfer(1'b0, 7'h46, {70{1'b1}});
        chk(got, pad_in);
        settle(stap_pkg::INS_SAMP, 1'b0);
    endtask
    task automatic t_rerst();
        load_ir(stap_pkg::INS_FLOAT);
        settle(stap_pkg::INS_FLOAT, 1'b1);
        rst_n = 1'b0;
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        t_id();
    endtask
    // ====
    // clock, ram clock never stops for the port
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial
    begin
        errors      = 0;
        check_count = 0;
        rst_n       = 1'b0;
        req_valid   = 1'b0;
        req_is_ir   = 1'b0;
        req_len     = 7'h00;
        req_data    = 70'h0;
        pad_in      = 70'h0;
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        t_id();
        t_byp(stap_pkg::INS_BYP, 1'b0);
        t_byp(stap_pkg::INS_FLOAT, 1'b1);
        t_byp(3'h0, 1'b0);
        t_byp(3'h5, 1'b0);
        t_byp(3'h6, 1'b0);
        t_byp(3'h7, 1'b0);
        t_samp();
        t_rerst();
        complete_run();
    end
endmodule // sram_tap_instruction_logic_tb
